// file: hw/uedb_pkg.sv
// package for the endpoint descriptor register bank
// assumes one clock domain and an 8-bit firmware data bus with 16-bit addresses
package uedb_pkg;
  localparam int          NUM_EP       = 4;
  localparam logic [3:0]  DESC_HI      = 4'hf;
  localparam logic [4:0]  DESC_ZERO    = 5'h00;
  localparam logic [3:0]  BUF_PREFIX   = 4'he;
  localparam logic [2:0]  ENT_CFG      = 3'h0;
  localparam logic [2:0]  ENT_XBASE    = 3'h1;
  localparam logic [2:0]  ENT_XCNTL    = 3'h2;
  localparam logic [2:0]  ENT_XCNTH    = 3'h3;
  localparam logic [2:0]  ENT_SIZE     = 3'h4;
  localparam logic [2:0]  ENT_YBASE    = 3'h5;
  localparam logic [2:0]  ENT_YCNTL    = 3'h6;
  localparam logic [2:0]  ENT_YCNTH    = 3'h7;
  localparam int          CFG_SECMEM   = 0;
  localparam int          CFG_TOGCLR   = 1;
  localparam int          CFG_TIRQ     = 2;
  localparam int          CFG_STALL    = 3;
  localparam int          CFG_DOUBLE_BUFFER_ENABLE     = 4;
  localparam int          CFG_TOGGLE   = 5;
  localparam int          CFG_NIRQ     = 6;
  localparam int          CFG_BMEN     = 7;
  localparam logic [7:0]  CFG_RW_MASK  = 8'hdd;
  localparam logic [7:0]  REG_RESET    = 8'h00;
  localparam logic [10:0] MAX_PKT_HS   = 11'h200;
  localparam logic [10:0] MAX_PKT_FS   = 11'h040;
endpackage

// file: hw/uedb_bank.sv
// endpoint descriptor register bank, endpoints 1..4 in and out
// assumes firmware bus and buffer manager events are on clk
//
// Summary of operation
// RULE1 - four in and four out endpoints, 1..4
// RULE2 - each holds X, Y buffer and status
// RULE3 - firmware picks double buffering per endpoint
// RULE4 - double buffering off after reset, X only
// RULE5 - address F, zeros, endpoint, direction, entry
// RULE6 - entry select maps the eight registers
// RULE7 - buffer address is E, base, four zeros
// RULE8 - max packet 512 high, 64 full speed
// RULE9 - bit 2 enables completion interrupt
// RULE10 - bit 3 makes endpoint answer with stall
// RULE11 - bit 6 enables refusal interrupt
// RULE12 - toggle picks X or Y when double buffered
// RULE13 - bit 7 lets buffer manager use endpoint
// RULE14 - toggle hardware owned, clear bit reads zero
// RULE15 - configuration bits reset to zero
`timescale 1ns/1ns
module uedb_bank
  import uedb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] fw_addr,
  input  wire logic        fw_wr,
  input  wire logic        fw_rd,
  input  wire logic [7:0]  fw_wdata,
  output logic      [7:0]  fw_rdata,
  output logic             fw_hit,
  input  wire logic [2:0]  bm_ep,
  input  wire logic        bm_out,
  input  wire logic        bm_high_speed,
  input  wire logic        bm_xfer_done,
  input  wire logic        bm_nak,
  output logic             bm_enable,
  output logic             bm_stall,
  output logic             bm_use_y,
  output logic      [15:0] bm_buf_addr,
  output logic      [10:0] bm_max_pkt,
  output logic             bm_secondary,
  output logic             ep_irq
);

  // ***********************************************
  // state
  // ***********************************************
  typedef logic [7:0] uedb_byte_t;
  typedef struct packed {
    uedb_byte_t [1:0][NUM_EP-1:0][7:0] regs;
    logic [7:0]  rdata;
    logic        hit;
    logic        en;
    logic        stall;
    logic        use_y;
    logic [15:0] baddr;
    logic [10:0] maxp;
    logic        sec;
    logic        irq;
  } uedb_state_t;

  uedb_state_t s_r;
  uedb_state_t s_nxt;

  // ***********************************************
  // decode and update
  // ***********************************************
  logic       fw_sel;
  logic       fw_dir;
  logic [1:0] fw_ep;
  logic [2:0] fw_ent;
  logic       bm_sel;
  logic [1:0] bm_idx;
  logic       bm_dir;
  logic [7:0] bm_cfg;
  logic       pick_y;

  always_comb
  begin
    s_nxt  = s_r;
    fw_dir = fw_addr[3];
    fw_ent = fw_addr[2:0];
    fw_ep  = 2'(fw_addr[6:4] - 3'h1);
    // only endpoints one to four answer inside the descriptor window
    fw_sel = 1'b0;
    if ((fw_addr[15:12] == DESC_HI) && (fw_addr[11:7] == DESC_ZERO)) // RULE5
    begin
      unique case (fw_addr[6:4])
        3'h1,
        3'h2,
        3'h3,
        3'h4:    fw_sel = 1'b1; // RULE1
        default: fw_sel = 1'b0;
      endcase
    end
    bm_sel = (bm_ep != 3'h0) && (bm_ep <= 3'h4); // RULE1
    bm_idx = 2'(bm_ep - 3'h1);
    bm_dir = bm_out;
    bm_cfg = s_r.regs[bm_dir][bm_idx][ENT_CFG];

    // hardware flips the toggle on each completed transaction
    if (bm_sel && bm_xfer_done)
      s_nxt.regs[bm_dir][bm_idx][ENT_CFG][CFG_TOGGLE] = ~bm_cfg[CFG_TOGGLE]; // RULE14

    s_nxt.hit   = fw_sel && (fw_rd || fw_wr);
    s_nxt.rdata = 8'h00;
    if (fw_sel && fw_rd)
    begin
      s_nxt.rdata = s_r.regs[fw_dir][fw_ep][fw_ent]; // RULE6 RULE2
      if (fw_ent == ENT_CFG)
        s_nxt.rdata[CFG_TOGCLR] = 1'b0; // RULE14
    end
    if (fw_sel && fw_wr)
    begin
      if (fw_ent == ENT_CFG)
      begin
        s_nxt.regs[fw_dir][fw_ep][ENT_CFG] = (fw_wdata & CFG_RW_MASK)
          | (s_nxt.regs[fw_dir][fw_ep][ENT_CFG] & ~CFG_RW_MASK); // RULE3 RULE14
        if (fw_wdata[CFG_TOGCLR])
          s_nxt.regs[fw_dir][fw_ep][ENT_CFG][CFG_TOGGLE] = 1'b0; // RULE14
      end
      else
        s_nxt.regs[fw_dir][fw_ep][fw_ent] = fw_wdata; // RULE6
    end

    pick_y      = bm_cfg[CFG_DOUBLE_BUFFER_ENABLE] && bm_cfg[CFG_TOGGLE]; // RULE12 RULE4
    s_nxt.en    = bm_sel && bm_cfg[CFG_BMEN]; // RULE13
    s_nxt.stall = bm_sel && bm_cfg[CFG_STALL]; // RULE10
    s_nxt.sec   = bm_sel && bm_cfg[CFG_SECMEM];
    s_nxt.use_y = bm_sel && pick_y;
    s_nxt.baddr = {BUF_PREFIX,
                   s_r.regs[bm_dir][bm_idx][pick_y ? ENT_YBASE : ENT_XBASE],
                   4'h0}; // RULE7
    s_nxt.maxp  = bm_high_speed ? MAX_PKT_HS : MAX_PKT_FS; // RULE8
    s_nxt.irq   = bm_sel && ((bm_xfer_done && bm_cfg[CFG_TIRQ])
                  || (bm_nak && bm_cfg[CFG_NIRQ])); // RULE9 RULE11
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0; // RULE15 RULE4
    else
      s_r <= s_nxt;
  end

  assign fw_rdata     = s_r.rdata;
  assign fw_hit       = s_r.hit;
  assign bm_enable    = s_r.en;
  assign bm_stall     = s_r.stall;
  assign bm_use_y     = s_r.use_y;
  assign bm_buf_addr  = s_r.baddr;
  assign bm_max_pkt   = s_r.maxp;
  assign bm_secondary = s_r.sec;
  assign ep_irq       = s_r.irq;

endmodule

// file: bench/uedb_asserts.sv
// port assertions for uedb_bank, bound by name
`timescale 1ns/1ns
module uedb_chk (input logic clk, rst_n, fw_rd, fw_wr, fw_hit, ep_irq,
  bm_high_speed, bm_xfer_done, bm_nak, input logic [15:0] fw_addr, bm_buf_addr,
  input logic [7:0] fw_rdata, input logic [10:0] bm_max_pkt);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire rq = fw_rd | fw_wr, map = fw_addr[15:7] == 9'h1e0 && fw_addr[6:4] inside {[1:4]};
  property p_hit; fw_hit |-> $past(map && rq); endproperty
  a_hit: assert property (p_hit) else $error("stray hit");
  property p_map; rq && map |=> fw_hit; endproperty
  a_map: assert property (p_map) else $error("lost hit");
  property p_unm; fw_rd && !map |=> !fw_rdata; endproperty
  a_unm: assert property (p_unm) else $error("stray data");
  property p_idl; !$past(fw_rd) |-> !fw_rdata; endproperty
  a_idl: assert property (p_idl) else $error("idle data");
  property p_clr; fw_rd && fw_addr[2:0] == 3'h0 |=> !fw_rdata[1]; endproperty
  a_clr: assert property (p_clr) else $error("clear bit");
  property p_buf; $past(rst_n) |-> {bm_buf_addr[15:12], bm_buf_addr[3:0]} == 8'he0; endproperty
  a_buf: assert property (p_buf) else $error("buffer");
  property p_pkt; $past(rst_n) |-> bm_max_pkt == ($past(bm_high_speed) ? 11'h200 : 11'h40);
  endproperty
  a_pkt: assert property (p_pkt) else $error("size");
  property p_irq; ep_irq |-> $past(bm_xfer_done | bm_nak); endproperty
  a_irq: assert property (p_irq) else $error("stray irq");
endmodule
bind uedb_bank uedb_chk u_chk (.*);

// file: bench/uedb_bm_model.sv
// buffer manager events: bench level is registered, reaching the outputs 1 ns after the next edge
`timescale 1ns/1ns
module uedb_bm_model (input logic clk, input logic [1:0] ev,
  output logic bm_xfer_done = 1'b0, bm_nak = 1'b0);
  always @(posedge clk) {bm_nak, bm_xfer_done} <= #1 ev;
endmodule

// file: bench/uedb_bank_tb.sv
// self-checking bench for uedb_bank, firmware bus driven here
`timescale 1ns/1ns
`define CK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module uedb_bank_tb import uedb_pkg::*;;
  logic clk = 0, rst_n = 0, fw_wr = 0, fw_rd = 0, bm_out = 0, bm_high_speed = 0, fw_hit;
  logic bm_xfer_done, bm_nak, bm_enable, bm_stall, bm_use_y, bm_secondary, ep_irq;
  logic [15:0] fw_addr = 0, bm_buf_addr;
  logic [10:0] bm_max_pkt;
  logic [7:0] fw_wdata = 0, fw_rdata;
  logic [2:0] bm_ep = 1;
  logic [1:0] ev = 0;
  int err_count = 0, checks = 0, cyc = 0;
  uedb_bank dut (.*);
  uedb_bm_model bm (.*);
  always #25 clk = ~clk;
  task acc(logic w, logic [15:0] a, logic [7:0] d, logic [8:0] e);
    {fw_wr, fw_rd, fw_addr, fw_wdata} = {w, !w, a, d};
    @(posedge clk) #5 `CK({fw_hit, fw_rdata}, e)
  endtask
  task evt(logic [1:0] k, logic x);
    {fw_wr, fw_rd, ev} = {2'h0, k};
    @(posedge clk) #5 ev = 0;
    @(posedge clk) #5 `CK(ep_irq, x)
  endtask
  task t_regs;
    for (int j = 1; j < 5; j++) acc(0, 16'hf000 + 16 * j, 0, 9'h100);
    for (int j = 0; j < 8; j++) acc(1, 16'hf048 + j, j * 37 - 1, 9'h100);
    for (int j = 0; j < 8; j++) acc(0, 16'hf048 + j, 0, {1'b1, j ? 8'(j * 37 - 1) : 8'hdd});
    acc(1, 16'hf088, 8'hff, 9'h0);
    acc(0, 16'hf050, 0, 9'h0);
  endtask
  task t_bm;
    acc(1, 16'hf011, 8'h12, 9'h100);
    acc(1, 16'hf015, 8'h34, 9'h100);
    acc(1, 16'hf010, 8'hdc, 9'h100);
    evt(0, 0);
    `CK({bm_enable, bm_stall, bm_use_y, bm_buf_addr}, 19'h6e120)
    evt(1, 1);
    @(posedge clk) #5 `CK({bm_use_y, bm_buf_addr}, 17'h1e340)
    acc(0, 16'hf010, 0, 9'h1fc);
    acc(1, 16'hf010, 8'hde, 9'h100);
    acc(0, 16'hf010, 0, 9'h1dc);
    evt(2, 1);
    acc(1, 16'hf010, 8'h80, 9'h100);
    evt(1, 0);
    @(posedge clk) #5 `CK({bm_use_y, bm_buf_addr}, 17'h0e120)
    bm_high_speed = 1;
    @(posedge clk) #5 `CK(bm_max_pkt, MAX_PKT_HS)
    {bm_out, bm_ep, bm_high_speed} = {1'b1, 3'h4, 1'b0};
    @(posedge clk) #5 `CK({bm_enable, bm_stall, bm_use_y, bm_secondary, bm_buf_addr}, 20'hde240)
    `CK(bm_max_pkt, MAX_PKT_FS)
    bm_ep = 3'h0;
    @(posedge clk) #5 `CK({bm_enable, bm_stall, bm_secondary}, 3'h0)
  endtask
  task finish_test;
    if (!err_count && checks) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 500) begin err_count++; finish_test; end
  initial
  begin
    repeat (8) @(posedge clk);
    #5 rst_n = 1;
    t_regs;
    t_bm;
    finish_test;
  end
endmodule
